// [rtl/gpm_port.v]
// GPIO port with pin position selector behind an APB slave
// What this block does
// RQ1 - After reset all drivers are off and all input buffers on.
// RQ2 - Drive-enable set strobe sets only the written one bits.
// RQ3 - Drive-enable clear strobe clears only the written one bits.
// RQ4 - Drive-enable toggle strobe inverts the written one bits.
// RQ5 - Drive-value set strobe sets written one bits; zeros change nothing.
// RQ6 - Drive-value clear strobe clears written one bits; zeros change nothing.
// RQ7 - Writing one to drive-value toggle or sample register inverts drive value.
// RQ8 - Pad levels pass a two-stage synchroniser and are readable in any direction.
// RQ9 - Pin n configuration register sits at index 0x10 plus n.
// RQ10 - Polarity flip inverts sampled level, and inverts driven value only while no peripheral override drives that pin.
// RQ11 - Changing polarity flip gives an edge seen by peripherals and sensing.
// RQ12 - Pull-up follows its enable bit but is off while the drive-enable bit is set.
// RQ13 - Input-disable sense stops buffer and synchroniser; sample holds its value.
// RQ14 - Aliased registers behave exactly like the regular ones.
// RQ15 - Eight pins per instance, bit n belongs to pin n.
// RQ16 - Pin change sensing raises a wake request for the power controller.
// RQ17 - Control A bits 5 and 4 move logic table outputs to alternative pins.
// RQ18 - Control A bits 0 to 2 enable event output pins 0 to 2.
// RQ19 - Control B bits 4, 2, 0 move two-wire, SPI, UART signals.
// RQ20 - Control C bits 0 to 2 move timer A outputs or low-byte channels.
// RQ21 - Control C bit 3 applies only while timer A is in split mode.
// RQ22 - Control D bit 0 moves timer B output to its alternative pin.
// RQ23 - Pins without peripheral override stay under port register control.
// RQ24 - Sense condition sets a flag; request stays while flag set and sensing on.
// RQ25 - Driver enabled when drive-enable is one and no override applies.
`timescale 1ns/100ps
`include "gpm_map.vh"

module gpm_port (
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// Pads
	input wire [7:0] pad_in,
	output reg [7:0] pad_out,
	output reg [7:0] pad_oe,
	output reg [7:0] pad_pullup,
	output reg [7:0] pad_ibuf_en,
	// Peripheral override, same clock
	input wire [7:0] ovr_en,
	input wire [7:0] ovr_oe,
	input wire [7:0] ovr_out,
	input wire timer_a_split,
	// Internal pin levels, events and requests
	output reg [7:0] pin_level,
	output reg [7:0] pin_event,
	output reg irq,
	output reg wake_req,
	// Pin position selections
	output reg logic_table_zero_alt,
	output reg logic_table_one_alt,
	output reg [2:0] evout_en,
	output reg twi_alt,
	output reg spi_alt,
	output reg uart_alt,
	output reg [3:0] timer_a_alt,
	output reg tcb_alt
);

	// ****************************************************************
	// Decode helpers
	// ****************************************************************

	// True when the index hits the regular or the aliased register
	function hit;
		input [7:0] idx;
		input [7:0] reg_idx;
		input [7:0] alias_idx;
		begin
			hit = (idx == reg_idx) || (idx == alias_idx);
		end
	endfunction

	// True for any mapped index
	function mapped;
		input [7:0] idx;
		begin
			mapped = (idx <= `GPM_FLAGS) ||
				(idx >= `GPM_PINCFG && idx <= `GPM_PINCFG + 8'h07) ||
				(idx >= `GPM_MUXA && idx <= `GPM_MUXD) ||
				(idx >= `GPM_VDIR && idx <= `GPM_VFLAGS);
		end
	endfunction

	// ****************************************************************
	// State
	// ****************************************************************

	reg [7:0] dir_reg, dir_next;
	reg [7:0] out_reg, out_next;
	reg [7:0] flag_reg, flag_next;
	reg [7:0] sync1_reg, sync1_next;
	reg [7:0] sync2_reg, sync2_next;
	reg [7:0] prev_reg;
	reg [7:0] cfg_reg [0:7];
	reg [7:0] cfg_next [0:7];
	reg [1:0] dead_reg [0:7];
	reg [1:0] dead_next [0:7];
	reg [7:0] muxa_reg, muxa_next;
	reg [7:0] muxb_reg, muxb_next;
	reg [7:0] muxc_reg, muxc_next;
	reg [7:0] muxd_reg, muxd_next;
	reg [7:0] flip, lvl, flag_set, sense_on, rd_byte;
	reg [2:0] sc;
	wire [7:0] idx;
	wire wr_en;
	wire [7:0] wd;
	integer i;

	// Word index from a byte address; misaligned addresses are refused
	assign idx = paddr[9:2];
	// A write lands only at the access edge, with the low lane strobed
	assign wr_en = psel & penable & pready & pwrite & ~pslverr & pstrb[0];
	assign wd = pwdata[7:0];

	// ****************************************************************
	// Next-state logic
	// ****************************************************************

	// Pin sensing, synchroniser and register writes
	always @* begin
		dir_next = dir_reg;
		out_next = out_reg;
		muxa_next = muxa_reg;
		muxb_next = muxb_reg;
		muxc_next = muxc_reg;
		muxd_next = muxd_reg;
		flip = 8'h00;
		lvl = 8'h00;
		flag_set = 8'h00;
		sense_on = 8'h00;
		sync1_next = sync1_reg;
		sync2_next = sync2_reg;
		sc = 3'h0;
		for (i = 0; i < 8; i = i + 1) begin // RQ15
			cfg_next[i] = cfg_reg[i];
			dead_next[i] = (dead_reg[i] != 2'h0) ? dead_reg[i] - 2'h1 : 2'h0;
			sc = cfg_reg[i][2:0];
			flip[i] = cfg_reg[i][`GPM_CFG_FLIP];
			// A disabled buffer freezes both stages, so the sample holds
			if (sc != `GPM_SC_INDIS) begin // RQ13
				sync1_next[i] = pad_in[i]; // RQ8
				sync2_next[i] = sync1_reg[i]; // RQ8
			end
			// Flip applies after the synchroniser, so a flip change is an edge
			lvl[i] = sync2_reg[i] ^ flip[i]; // RQ10 RQ11
			sense_on[i] = (sc == `GPM_SC_BOTH) || (sc == `GPM_SC_RISE) ||
				(sc == `GPM_SC_FALL) || (sc == `GPM_SC_LOW);
			if (dead_reg[i] == 2'h0) begin
				case (sc)
					`GPM_SC_BOTH: flag_set[i] = lvl[i] ^ prev_reg[i]; // RQ24
					`GPM_SC_RISE: flag_set[i] = lvl[i] & ~prev_reg[i]; // RQ24
					`GPM_SC_FALL: flag_set[i] = ~lvl[i] & prev_reg[i]; // RQ24
					`GPM_SC_LOW: flag_set[i] = ~lvl[i]; // RQ24
					default: flag_set[i] = 1'b0;
				endcase
			end
			if (flag_set[i])
				dead_next[i] = `GPM_DEAD_CYC;
		end
		// A new event wins over a clear in the same cycle
		flag_next = flag_reg | flag_set; // RQ24
		if (wr_en) begin
			if (hit(idx, `GPM_DIR, `GPM_VDIR)) begin
				dir_next = wd; // RQ14
			end else if (idx == `GPM_DRV_EN_SET) begin
				dir_next = dir_reg | wd; // RQ2
			end else if (idx == `GPM_DRV_EN_CLR) begin
				dir_next = dir_reg & ~wd; // RQ3
			end else if (idx == `GPM_DRV_EN_TGL) begin
				dir_next = dir_reg ^ wd; // RQ4
			end else if (hit(idx, `GPM_OUT, `GPM_VOUT)) begin
				out_next = wd; // RQ14
			end else if (idx == `GPM_DRV_VAL_SET) begin
				out_next = out_reg | wd; // RQ5
			end else if (idx == `GPM_DRV_VAL_CLR) begin
				out_next = out_reg & ~wd; // RQ6
			end else if (idx == `GPM_DRV_VAL_TGL || hit(idx, `GPM_IN, `GPM_VIN)) begin
				out_next = out_reg ^ wd; // RQ7 RQ14
			end else if (hit(idx, `GPM_FLAGS, `GPM_VFLAGS)) begin
				flag_next = (flag_reg & ~wd) | flag_set; // RQ14 RQ24
			end else if (idx >= `GPM_PINCFG && idx <= `GPM_PINCFG + 8'h07) begin
				cfg_next[idx[2:0]] = wd; // RQ9
			end else if (idx == `GPM_MUXA) begin
				muxa_next = wd & `GPM_MUXA_MASK; // RQ17 RQ18
			end else if (idx == `GPM_MUXB) begin
				muxb_next = wd & `GPM_MUXB_MASK; // RQ19
			end else if (idx == `GPM_MUXC) begin
				muxc_next = wd & `GPM_MUXC_MASK; // RQ20
			end else if (idx == `GPM_MUXD) begin
				muxd_next = wd & `GPM_MUXD_MASK; // RQ22
			end
		end
	end

	// Read data, chosen in the setup cycle and shown in the access cycle
	always @* begin
		rd_byte = 8'h00;
		if (hit(idx, `GPM_DIR, `GPM_VDIR)) begin
			rd_byte = dir_reg; // RQ14
		end else if (idx >= `GPM_DRV_EN_SET && idx <= `GPM_DRV_EN_TGL) begin
			rd_byte = dir_reg;
		end else if (hit(idx, `GPM_OUT, `GPM_VOUT)) begin
			rd_byte = out_reg; // RQ14
		end else if (idx >= `GPM_DRV_VAL_SET && idx <= `GPM_DRV_VAL_TGL) begin
			rd_byte = out_reg;
		end else if (hit(idx, `GPM_IN, `GPM_VIN)) begin
			rd_byte = lvl; // RQ8 RQ10 RQ14
		end else if (hit(idx, `GPM_FLAGS, `GPM_VFLAGS)) begin
			rd_byte = flag_reg; // RQ14
		end else if (idx >= `GPM_PINCFG && idx <= `GPM_PINCFG + 8'h07) begin
			rd_byte = cfg_reg[idx[2:0]]; // RQ9
		end else if (idx == `GPM_MUXA) begin
			rd_byte = muxa_reg;
		end else if (idx == `GPM_MUXB) begin
			rd_byte = muxb_reg;
		end else if (idx == `GPM_MUXC) begin
			rd_byte = muxc_reg;
		end else if (idx == `GPM_MUXD) begin
			rd_byte = muxd_reg;
		end
	end

	// ****************************************************************
	// Registers
	// ****************************************************************

	// Port state and sensing
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dir_reg <= `GPM_REG_RESET; // RQ1
			out_reg <= `GPM_REG_RESET;
			flag_reg <= `GPM_REG_RESET;
			sync1_reg <= `GPM_REG_RESET;
			sync2_reg <= `GPM_REG_RESET;
			prev_reg <= `GPM_REG_RESET;
			muxa_reg <= `GPM_REG_RESET;
			muxb_reg <= `GPM_REG_RESET;
			muxc_reg <= `GPM_REG_RESET;
			muxd_reg <= `GPM_REG_RESET;
			for (i = 0; i < 8; i = i + 1) begin
				cfg_reg[i] <= `GPM_CFG_RESET; // RQ1
				dead_reg[i] <= 2'h0;
			end
		end else begin
			dir_reg <= dir_next;
			out_reg <= out_next;
			flag_reg <= flag_next;
			sync1_reg <= sync1_next;
			sync2_reg <= sync2_next;
			prev_reg <= lvl;
			muxa_reg <= muxa_next;
			muxb_reg <= muxb_next;
			muxc_reg <= muxc_next;
			muxd_reg <= muxd_next;
			for (i = 0; i < 8; i = i + 1) begin
				cfg_reg[i] <= cfg_next[i];
				dead_reg[i] <= dead_next[i];
			end
		end
	end

	// APB answer: one wait-free access phase after every setup cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & ~penable;
			pslverr <= psel & ~penable & (~mapped(idx) | (paddr[1:0] != 2'h0) |
				(paddr[11:10] != 2'h0));
			// A refused read returns zero, never the byte of an aliased index
			prdata <= (psel & ~penable & ~pwrite & mapped(idx) & (paddr[1:0] == 2'h0) &
				(paddr[11:10] == 2'h0)) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
		end
	end

	// Pad drive, pull-up and buffer enables; override takes the driver
	// only for pins a peripheral has claimed, the rest stay GPIO
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pad_out <= 8'h00;
			pad_oe <= 8'h00; // RQ1
			pad_pullup <= 8'h00;
			pad_ibuf_en <= 8'hff; // RQ1
			pin_level <= 8'h00;
			pin_event <= 8'h00;
			irq <= 1'b0;
			wake_req <= 1'b0;
		end else begin
			for (i = 0; i < 8; i = i + 1) begin
				pad_oe[i] <= ovr_en[i] ? ovr_oe[i] : dir_next[i]; // RQ23 RQ25
				pad_out[i] <= ovr_en[i] ? ovr_out[i] : (out_next[i] ^ // RQ23 RQ25
					cfg_next[i][`GPM_CFG_FLIP]); // RQ10 RQ11
				pad_pullup[i] <= cfg_next[i][`GPM_CFG_PULL] & ~dir_next[i]; // RQ12
				pad_ibuf_en[i] <= cfg_next[i][2:0] != `GPM_SC_INDIS; // RQ13
			end
			pin_level <= lvl; // RQ11
			// Events read zero while the input buffer is off
			pin_event <= lvl & pad_ibuf_en;
			irq <= |(flag_next & sense_on); // RQ24
			// Only sync-path sensing here; a clock-free wake path needs a
			// pad-level cell outside this block
			wake_req <= |flag_set; // RQ16
		end
	end

	// Pin position selections
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			logic_table_zero_alt <= 1'b0;
			logic_table_one_alt <= 1'b0;
			evout_en <= 3'h0;
			twi_alt <= 1'b0;
			spi_alt <= 1'b0;
			uart_alt <= 1'b0;
			timer_a_alt <= 4'h0;
			tcb_alt <= 1'b0;
		end else begin
			logic_table_one_alt <= muxa_next[5]; // RQ17
			logic_table_zero_alt <= muxa_next[4]; // RQ17
			evout_en <= muxa_next[2:0]; // RQ18
			twi_alt <= muxb_next[4]; // RQ19
			spi_alt <= muxb_next[2]; // RQ19
			uart_alt <= muxb_next[0]; // RQ19
			timer_a_alt[2:0] <= muxc_next[2:0]; // RQ20
			timer_a_alt[3] <= muxc_next[3] & timer_a_split; // RQ21
			tcb_alt <= muxd_next[0]; // RQ22
		end
	end

endmodule // gpm_port

// [rtl/gpm_map.vh]
// Register indexes, field positions and reset values of the GPIO port block
`ifndef GPM_MAP_VH
`define GPM_MAP_VH
// Register indexes; byte address is four times the index
`define GPM_DIR 8'h00
`define GPM_DRV_EN_SET 8'h01
`define GPM_DRV_EN_CLR 8'h02
`define GPM_DRV_EN_TGL 8'h03
`define GPM_OUT 8'h04
`define GPM_DRV_VAL_SET 8'h05
`define GPM_DRV_VAL_CLR 8'h06
`define GPM_DRV_VAL_TGL 8'h07
`define GPM_IN 8'h08
`define GPM_FLAGS 8'h09
`define GPM_PINCFG 8'h10
`define GPM_MUXA 8'h30
`define GPM_MUXB 8'h31
`define GPM_MUXC 8'h32
`define GPM_MUXD 8'h33
`define GPM_VDIR 8'h38
`define GPM_VOUT 8'h39
`define GPM_VIN 8'h3a
`define GPM_VFLAGS 8'h3b
// Writable bits of the pin position registers
`define GPM_MUXA_MASK 8'h37
`define GPM_MUXB_MASK 8'h15
`define GPM_MUXC_MASK 8'h0f
`define GPM_MUXD_MASK 8'h01
// Per-pin configuration fields
`define GPM_CFG_FLIP 7
`define GPM_CFG_PULL 3
`define GPM_CFG_RESET 8'h00
// Sense configuration codes
`define GPM_SC_OFF 3'h0
`define GPM_SC_BOTH 3'h1
`define GPM_SC_RISE 3'h2
`define GPM_SC_FALL 3'h3
`define GPM_SC_INDIS 3'h4
`define GPM_SC_LOW 3'h5
// Cycles with no new flag after one was raised
`define GPM_DEAD_CYC 2'h3
`define GPM_REG_RESET 8'h00
`endif

// [dv/gpm_port_monitor.sv]
// Concurrent checks on the pins of the GPIO port block
`timescale 1ns/100ps
module gpm_port_mon (
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// Bus
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire pready,
	input wire pslverr,
	input wire [31:0] prdata,
	// Pads and overrides
	input wire [7:0] pad_out,
	input wire [7:0] pad_oe,
	input wire [7:0] pad_pullup,
	input wire [7:0] pad_ibuf_en,
	input wire [7:0] ovr_en,
	input wire [7:0] ovr_oe,
	input wire [7:0] ovr_out,
	input wire timer_a_split,
	// Pin position selections
	input wire logic_table_zero_alt,
	input wire logic_table_one_alt,
	input wire [2:0] evout_en,
	input wire twi_alt,
	input wire spi_alt,
	input wire uart_alt,
	input wire [3:0] timer_a_alt,
	input wire tcb_alt
);
	// ****
	// Helpers
	// ****
	wire acc_wr = psel & penable & pwrite;
	// Bit 3 of timer A follows split mode too, so it stays out of this vector
	wire [11:0] mux_v = {logic_table_zero_alt, logic_table_one_alt, evout_en, twi_alt, spi_alt,
		uart_alt, tcb_alt, timer_a_alt[2:0]};
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_reset_pads: assert property ($rose(presetn) |-> !pad_oe && !pad_pullup && &pad_ibuf_en)
		else $error("pads not idle after reset");
	a_ready_pulse: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("ready not a single pulse after setup");
	a_err_nodata: assert property (pslverr |-> pready && prdata == 32'h00000000)
		else $error("error without ready or with data");
	a_pull_off_out: assert property (!$past(ovr_en) |-> !(pad_pullup & pad_oe))
		else $error("pull-up on a driving pin");
	a_ovr_drive: assert property (ovr_en != 8'h00 |=> !((pad_oe ^ $past(ovr_oe)) & $past(ovr_en))
		&& !((pad_out ^ $past(ovr_out)) & $past(ovr_en)))
		else $error("override not on the pad");
	a_split_only: assert property (!timer_a_split |=> !timer_a_alt[3])
		else $error("wave 3 moved outside split mode");
	a_mux_by_write: assert property ($changed(mux_v) |-> $past(acc_wr) || $past(acc_wr, 2))
		else $error("pin selection changed without a write");
	a_ibuf_by_write: assert property ($changed(pad_ibuf_en) |-> $past(acc_wr) || $past(acc_wr, 2))
		else $error("input buffer changed without a write");
endmodule // gpm_port_mon

bind gpm_port gpm_port_mon u_gpm_port_mon (.pclk, .presetn, .psel, .penable, .pwrite, .pready,
	.pslverr, .prdata, .pad_out, .pad_oe, .pad_pullup, .pad_ibuf_en, .ovr_en, .ovr_oe, .ovr_out,
	.timer_a_split, .logic_table_zero_alt, .logic_table_one_alt, .evout_en, .twi_alt, .spi_alt,
	.uart_alt, .timer_a_alt, .tcb_alt);

// [dv/tb.sv]
// Self-checking bench for the GPIO port block
`timescale 1ns/100ps
`include "gpm_map.vh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; \
	$display("wrong value at %0t: got %h want %h", $time, g, e); end end
module tb;
	// ****
	// Signals and design
	// ****
	reg pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	reg timer_a_split = 1'h0;
	reg [11:0] paddr = 12'h000;
	reg [31:0] pwdata = 32'h0, rdat;
	reg [7:0] pad_in = 8'h00, ovr_en = 8'h00, ovr_oe = 8'h00, ovr_out = 8'h00, i;
	reg [3:0] pstrb = 4'hf;
	reg err;
	wire [31:0] prdata;
	wire pready, pslverr, irq, wake_req, logic_table_zero_alt, logic_table_one_alt;
	wire twi_alt, spi_alt, uart_alt, tcb_alt;
	wire [7:0] pad_out, pad_oe, pad_pullup, pad_ibuf_en, pin_level, pin_event;
	wire [2:0] evout_en;
	wire [3:0] timer_a_alt;
	integer failures = 0, n_checks = 0, cyc = 0, tn = 0;
	gpm_port u_gpm_port (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
		.prdata, .pready, .pslverr, .pad_in, .pad_out, .pad_oe, .pad_pullup, .pad_ibuf_en,
		.ovr_en, .ovr_oe, .ovr_out, .timer_a_split, .pin_level, .pin_event, .irq, .wake_req,
		.logic_table_zero_alt, .logic_table_one_alt, .evout_en, .twi_alt, .spi_alt, .uart_alt,
		.timer_a_alt, .tcb_alt);
	// Clock and hang guard; the run needs under two hundred cycles
	always #20 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			failures++;
			print_verdict;
		end
	end
	// ****
	// Bus tasks
	// ****
	function [11:0] ba(input [7:0] x);
		ba = {2'h0, x, 2'h0};
	endfunction
	// Request held until ready is seen; one idle cycle keeps strobes single per step
	task apb(input [11:0] a, input w, input [7:0] d);
		begin
			@(posedge pclk);
			psel <= 1'h1;
			pwrite <= w;
			paddr <= a;
			pwdata <= {24'h0, d};
			@(posedge pclk);
			penable <= 1'h1;
			@(posedge pclk);
			// Answer taken at the rising edge that sees ready high, then released
			while (pready !== 1'h1) @(posedge pclk);
			rdat = prdata;
			err = pslverr;
			psel <= 1'h0;
			penable <= 1'h0;
		end
	endtask
	task wr(input [11:0] a, input [7:0] d);
		apb(a, 1'h1, d);
	endtask
	task rd(input [11:0] a, input [7:0] e);
		begin
			apb(a, 1'h0, 8'h00);
			`CHK({err, rdat}, {25'h0, e})
		end
	endtask
	task settle;
		repeat (6) @(negedge pclk);
	endtask
	task done;
		begin
			tn++;
			$display("test %0d ended, mismatches so far %0d", tn, failures);
		end
	endtask
	task print_verdict;
		begin
			$display("comparisons %0d mismatches %0d", n_checks, failures);
			if (failures == 0 && n_checks > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask
	// ****
	// Tests
	// ****
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'h1;
		`CHK({pad_oe, pad_ibuf_en}, 16'h00ff)
		for (i = 8'h00; i < 8'h04; i = i + 8'h01)
			rd(ba(`GPM_MUXA + i), 8'h00);
		rd(ba(`GPM_PINCFG), `GPM_CFG_RESET);
		done;
		wr(ba(`GPM_DRV_EN_SET), 8'h81);
		wr(ba(`GPM_DRV_EN_SET), 8'h06);
		rd(ba(`GPM_DIR), 8'h87);
		wr(ba(`GPM_DRV_EN_CLR), 8'h03);
		rd(ba(`GPM_DIR), 8'h84);
		wr(ba(`GPM_DRV_EN_TGL), 8'h0c);
		rd(ba(`GPM_DIR), 8'h88);
		`CHK(pad_oe, 8'h88)
		done;
		wr(ba(`GPM_DRV_VAL_SET), 8'hf0);
		wr(ba(`GPM_DRV_VAL_CLR), 8'h30);
		rd(ba(`GPM_OUT), 8'hc0);
		wr(ba(`GPM_DRV_VAL_TGL), 8'h0f);
		wr(ba(`GPM_IN), 8'h81);
		rd(ba(`GPM_VOUT), 8'h4e);
		`CHK(pad_out, 8'h4e)
		wr(ba(`GPM_VDIR), 8'h11);
		rd(ba(`GPM_DIR), 8'h11);
		done;
		@(posedge pclk) pad_in <= 8'h3c;
		settle;
		rd(ba(`GPM_IN), 8'h3c);
		wr(ba(`GPM_PINCFG + 8'h02), 8'h80);
		rd(ba(`GPM_IN), 8'h38);
		`CHK({pin_level, pad_out}, 16'h384a)
		done;
		wr(ba(`GPM_PINCFG), 8'h08);
		settle;
		`CHK(pad_pullup, 8'h00)
		wr(ba(`GPM_DRV_EN_CLR), 8'h01);
		settle;
		`CHK(pad_pullup, 8'h01)
		done;
		wr(ba(`GPM_PINCFG + 8'h03), {5'h00, `GPM_SC_INDIS});
		@(posedge pclk) pad_in <= 8'h34;
		settle;
		`CHK(pad_ibuf_en, 8'hf7)
		rd(ba(`GPM_IN), 8'h38);
		`CHK(pin_event[3], 1'h0)
		done;
		wr(ba(`GPM_PINCFG + 8'h01), {5'h00, `GPM_SC_RISE});
		@(posedge pclk) pad_in <= 8'h36;
		// Two sync stages, then the flag edge launches the one-cycle wake pulse
		repeat (3) @(posedge pclk);
		@(negedge pclk);
		`CHK(wake_req, 1'h1)
		settle;
		`CHK(irq, 1'h1)
		rd(ba(`GPM_FLAGS), 8'h02);
		wr(ba(`GPM_VFLAGS), 8'h02);
		rd(ba(`GPM_FLAGS), 8'h00);
		`CHK(irq, 1'h0)
		done;
		for (i = 8'h00; i < 8'h04; i = i + 8'h01)
			wr(ba(`GPM_MUXA + i), 8'hff);
		rd(ba(`GPM_MUXA), `GPM_MUXA_MASK);
		rd(ba(`GPM_MUXB), `GPM_MUXB_MASK);
		rd(ba(`GPM_MUXC), `GPM_MUXC_MASK);
		rd(ba(`GPM_MUXD), `GPM_MUXD_MASK);
		`CHK({logic_table_one_alt, logic_table_zero_alt, evout_en}, 5'h1f)
		`CHK({twi_alt, spi_alt, uart_alt, tcb_alt}, 4'hf)
		`CHK(timer_a_alt, 4'h7)
		@(posedge pclk) timer_a_split <= 1'h1;
		wr(ba(`GPM_MUXA), 8'h10);
		settle;
		`CHK({timer_a_alt, logic_table_one_alt, logic_table_zero_alt, evout_en}, 9'h1e8)
		done;
		apb(12'h028, 1'h0, 8'h00);
		`CHK({err, rdat}, 33'h100000000)
		apb(12'h001, 1'h1, 8'hff);
		`CHK(err, 1'h1)
		rd(ba(`GPM_DIR), 8'h10);
		done;
		@(posedge pclk) begin
			ovr_en <= 8'hf0;
			ovr_oe <= 8'ha0;
			ovr_out <= 8'h50;
		end
		settle;
		`CHK({pad_oe, pad_out}, 16'ha05a)
		done;
		print_verdict;
	end
endmodule // tb
